/* File: verilog/udc_pkg.sv */
// Constants shared by the four-bit up/down counter block
package udc_pkg;

   localparam int unsigned COUNT_WIDTH = 4;
   localparam logic [3:0] COUNT_RESET = 4'h0;
   localparam logic [3:0] COUNT_MAX = 4'hf;
   localparam logic [3:0] COUNT_MIN = 4'h0;
   localparam logic [3:0] COUNT_STEP = 4'h1;
   // Count inputs idle high, so the edge history starts high
   localparam logic EDGE_IDLE = 1'b1;

endpackage

/* File: verilog/udc_edge_detect.sv */
// Rising edge detector for a group of synchronous level inputs
`timescale 1ns/10ps
module udc_edge_detect
#(
   parameter int unsigned WIDTH = 2
)
(
   input wire logic sys_clk,
   input wire logic rst_b,
   input wire logic [WIDTH-1:0] level,
   output logic [WIDTH-1:0] rise
);

   logic [WIDTH-1:0] last_q;
   logic [WIDTH-1:0] last_d;

   always_comb
   begin
      last_d = level;
   end

   always_ff @(posedge sys_clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         last_q <= {WIDTH{udc_pkg::EDGE_IDLE}};
      end
      else
      begin
         last_q <= last_d;
      end
   end

   assign rise = level & ~last_q;

endmodule

/* File: verilog/udc_counter.sv */
// Four-bit up/down counter with asynchronous load and clear, active-low carry and borrow
`timescale 1ns/10ps
module udc_counter
#(
   parameter int unsigned WIDTH = udc_pkg::COUNT_WIDTH
)
(
   input wire logic sys_clk,
   input wire logic rst_b,
   input wire logic count_up_clock,
   input wire logic count_down_clock,
   input wire logic parallel_load_n,
   input wire logic master_clear,
   input wire logic [WIDTH-1:0] preset_value,
   output logic [WIDTH-1:0] count_value,
   output logic carry_out_n,
   output logic borrow_out_n
);

   ////////////////////////////////////////////////////////////////////////////////
   // Edge detection of the two count inputs

   logic [1:0] rise;
   logic up_rise;
   logic down_rise;

   udc_edge_detect #(.WIDTH(2)) u_edge
   (
      .sys_clk(sys_clk),
      .rst_b(rst_b),
      .level({count_down_clock, count_up_clock}),
      .rise(rise)
   );

   assign up_rise = rise[0];
   assign down_rise = rise[1];

   ////////////////////////////////////////////////////////////////////////////////
   // Count register

   logic [WIDTH-1:0] count_q;
   logic [WIDTH-1:0] count_d;

   function automatic logic at_value(input logic [WIDTH-1:0] cnt, input logic [WIDTH-1:0] ref_v);
      at_value = (cnt == ref_v);
   endfunction

   always_comb
   begin
      count_d = count_q;
      if (master_clear)
      begin
         count_d = udc_pkg::COUNT_RESET;
      end
      else if (!parallel_load_n)
      begin
         count_d = preset_value;
      end
      else if (up_rise && count_down_clock)
      begin
         // Modulo add gives the wrap from fifteen to zero
         count_d = WIDTH'(count_q + udc_pkg::COUNT_STEP);
      end
      else if (down_rise && count_up_clock)
      begin
         count_d = WIDTH'(count_q - udc_pkg::COUNT_STEP);
      end
      // Both inputs rising together means both were low, which the driver must avoid;
      // the up branch then matches first, since the down input is high, so the count adds one.
   end

   always_ff @(posedge sys_clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         count_q <= udc_pkg::COUNT_RESET;
      end
      else
      begin
         count_q <= count_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Outputs

   // Clear and load bypass the register so they act without waiting for a clock edge;
   // the trade is a combinational path from those pins to the count outputs.
   always_comb
   begin
      if (master_clear)
      begin
         count_value = udc_pkg::COUNT_RESET;
      end
      else if (!parallel_load_n)
      begin
         count_value = preset_value;
      end
      else
      begin
         count_value = count_q;
      end
   end

   // Plain decodes of the visible count and input level, no flip-flop in the path
   assign carry_out_n = !(at_value(count_value, udc_pkg::COUNT_MAX) && !count_up_clock);
   assign borrow_out_n = !(at_value(count_value, udc_pkg::COUNT_MIN) && !count_down_clock);

   ////////////////////////////////////////////////////////////////////////////////
   // Checks

   default clocking cb @(posedge sys_clk);
   endclocking

   default disable iff (!rst_b);

   logic idle_ctrl;
   assign idle_ctrl = !master_clear && parallel_load_n;

   property p_hold_without_edge;
      idle_ctrl && !up_rise && !down_rise |=> count_q == $past(count_q);
   endproperty
   a_hold_without_edge: assert property (p_hold_without_edge)
      else $error("count changed without a count edge");

   property p_count_up;
      idle_ctrl && up_rise && count_down_clock
         |=> count_q == WIDTH'($past(count_q) + udc_pkg::COUNT_STEP);
   endproperty
   a_count_up: assert property (p_count_up)
      else $error("up edge did not add one");

   property p_count_down;
      idle_ctrl && down_rise && count_up_clock
         |=> count_q == WIDTH'($past(count_q) - udc_pkg::COUNT_STEP);
   endproperty
   a_count_down: assert property (p_count_down)
      else $error("down edge did not subtract one");

   property p_rest_high;
      (!at_value(count_value, udc_pkg::COUNT_MAX) || count_up_clock) &&
      (!at_value(count_value, udc_pkg::COUNT_MIN) || count_down_clock)
         |-> carry_out_n && borrow_out_n;
   endproperty
   a_rest_high: assert property (p_rest_high)
      else $error("terminal output low without its condition");

   property p_carry_low;
      at_value(count_value, udc_pkg::COUNT_MAX) && !count_up_clock |-> !carry_out_n;
   endproperty
   a_carry_low: assert property (p_carry_low)
      else $error("carry not low at fifteen with up input low");

   property p_carry_release;
      !carry_out_n ##1 count_up_clock |-> carry_out_n;
   endproperty
   a_carry_release: assert property (p_carry_release)
      else $error("carry stayed low after up input rose");

   property p_borrow;
      borrow_out_n == !(at_value(count_value, udc_pkg::COUNT_MIN) && !count_down_clock);
   endproperty
   a_borrow: assert property (p_borrow)
      else $error("borrow does not match zero count and down level");

   property p_load;
      !master_clear && !parallel_load_n
         |-> count_value == preset_value ##1 count_q == $past(preset_value);
   endproperty
   a_load: assert property (p_load)
      else $error("load did not take the preset");

   property p_clear;
      master_clear |-> count_value == udc_pkg::COUNT_RESET ##1 count_q == udc_pkg::COUNT_RESET;
   endproperty
   a_clear: assert property (p_clear)
      else $error("clear did not force zero");

   property p_wrap_up;
      idle_ctrl && up_rise && count_down_clock && at_value(count_q, udc_pkg::COUNT_MAX)
         |=> at_value(count_q, udc_pkg::COUNT_MIN);
   endproperty
   a_wrap_up: assert property (p_wrap_up)
      else $error("up count did not wrap to zero");

   property p_wrap_down;
      idle_ctrl && down_rise && count_up_clock && at_value(count_q, udc_pkg::COUNT_MIN)
         |=> at_value(count_q, udc_pkg::COUNT_MAX);
   endproperty
   a_wrap_down: assert property (p_wrap_down)
      else $error("down count did not wrap to fifteen");

   property p_carry_follows_level;
      at_value(count_value, udc_pkg::COUNT_MAX) && $fell(count_up_clock) |-> !carry_out_n;
   endproperty
   a_carry_follows_level: assert property (p_carry_follows_level)
      else $error("carry lagged the up input level");

   // A count edge that lands under a load must not disturb the loaded value
   property p_load_blocks_edge;
      !master_clear && !parallel_load_n && (up_rise || down_rise)
         |=> count_q == $past(preset_value);
   endproperty
   a_load_blocks_edge: assert property (p_load_blocks_edge)
      else $error("count edge acted while load was low");

   property p_load_release;
      !master_clear && !parallel_load_n ##1 idle_ctrl && !up_rise && !down_rise
         |-> count_value == $past(preset_value);
   endproperty
   a_load_release: assert property (p_load_release)
      else $error("count did not keep the last preset after load");

   property p_borrow_low;
      at_value(count_value, udc_pkg::COUNT_MIN) && !count_down_clock |-> !borrow_out_n;
   endproperty
   a_borrow_low: assert property (p_borrow_low)
      else $error("borrow not low at zero with down input low");

   property p_borrow_release;
      !borrow_out_n ##1 count_down_clock |-> borrow_out_n;
   endproperty
   a_borrow_release: assert property (p_borrow_release)
      else $error("borrow stayed low after down input rose");

   c_wrap_up: cover property (idle_ctrl && up_rise && at_value(count_q, udc_pkg::COUNT_MAX));
   c_wrap_down: cover property (idle_ctrl && down_rise && at_value(count_q, udc_pkg::COUNT_MIN));
   c_load: cover property (!master_clear && !parallel_load_n ##1 parallel_load_n);
   c_clear_over_load: cover property (master_clear && !parallel_load_n);
   c_borrow_pulse: cover property (!borrow_out_n ##1 borrow_out_n);

endmodule

/* File: verification/udc_ctl_model.sv */
// Control-side model that turns count requests into idle-high count inputs
`timescale 1ns/10ps
module udc_ctl_model
(
   input wire logic req_up,
   input wire logic req_dn,
   output logic count_up_clock,
   output logic count_down_clock
);
   // Up request wins, so the two count inputs are never low together
   assign count_up_clock = ~req_up;
   assign count_down_clock = ~req_dn | req_up;
endmodule

/* File: verification/testbench.sv */
// Self-checking bench for the four-bit up/down counter
`timescale 1ns/10ps
module testbench;
   logic sys_clk, rst_b, req_up, req_dn, parallel_load_n, master_clear;
   logic cu, cd, carry_out_n, borrow_out_n;
   logic [3:0] preset_value, cnt, cur;
   int fail_count = 0, num_checks = 0, cycles = 0;
   // Row: op (0 up, 1 down, 2 load), preset, expected count
   logic [9:0] rows [0:7] = '{{2'h2, 4'he, 4'he}, {2'h0, 4'h0, 4'hf}, {2'h0, 4'h0, 4'h0},
      {2'h1, 4'h0, 4'hf}, {2'h1, 4'h0, 4'he}, {2'h2, 4'h1, 4'h1}, {2'h1, 4'h0, 4'h0},
      {2'h0, 4'h0, 4'h1}};

   udc_ctl_model u_udc_ctl_model (.req_up(req_up), .req_dn(req_dn),
      .count_up_clock(cu), .count_down_clock(cd));
   udc_counter u_udc_counter (.sys_clk(sys_clk), .rst_b(rst_b), .count_up_clock(cu),
      .count_down_clock(cd), .parallel_load_n(parallel_load_n), .master_clear(master_clear),
      .preset_value(preset_value), .count_value(cnt), .carry_out_n(carry_out_n),
      .borrow_out_n(borrow_out_n));

   ////////////////////////////////////////////////////////////////////////////////
   task automatic chk(input logic [3:0] g, input logic [3:0] e, input string m);
      num_checks++;
      if (g !== e)
      begin
         fail_count++;
         $display("BAD %0t %s", $time, m);
      end
   endtask

   task automatic end_sim;
      $display("checks %0d mismatches %0d", num_checks, fail_count);
      if (fail_count == 0 && num_checks > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask

   // Count input is low for one full cycle, then rises and is seen at the next edge
   task automatic do_op(input logic [9:0] r);
      @(negedge sys_clk);
      if (r[9:8] == 2'h2)
      begin
         parallel_load_n = 1'b0;
         preset_value = r[7:4];
         #1 chk(cnt, r[7:4], "load not immediate");
      end
      else
      begin
         req_up = (r[9:8] == 2'h0);
         req_dn = (r[9:8] == 2'h1);
         #1 chk({3'h0, carry_out_n}, {3'h0, !(req_up && cur == 4'hf)}, "carry");
         chk({3'h0, borrow_out_n}, {3'h0, !(req_dn && cur == 4'h0)}, "borrow");
      end
      @(negedge sys_clk);
      parallel_load_n = 1'b1;
      req_up = 1'b0;
      req_dn = 1'b0;
      // Terminal outputs must let go as the input rises, before any counting edge
      #1 chk({2'h0, carry_out_n, borrow_out_n}, 4'h3, "terminal held after input rose");
      @(negedge sys_clk);
      chk(cnt, r[3:0], "count");
      chk({3'h0, carry_out_n, borrow_out_n}, 4'h3, "terminal not idle");
      cur = r[3:0];
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   initial
   begin
      sys_clk = 1'b0;
      forever #5 sys_clk = ~sys_clk;
   end

   always @(posedge sys_clk)
   begin
      cycles++;
      if (cycles == 2000)
      begin
         fail_count++;
         end_sim();
      end
   end

   initial
   begin
      rst_b = 1'b0;
      {req_up, req_dn, master_clear} = 3'h0;
      parallel_load_n = 1'b1;
      preset_value = 4'h0;
      cur = 4'h0;
      repeat (20) @(negedge sys_clk);
      chk(cnt, 4'h0, "reset count");
      rst_b = 1'b1;
      foreach (rows[i])
         do_op(rows[i]);
      $display("table test done");
      // Clear beats load and count; an up edge seen while load is low is dropped
      @(negedge sys_clk);
      parallel_load_n = 1'b0;
      preset_value = 4'ha;
      master_clear = 1'b1;
      req_up = 1'b1;
      #1 chk(cnt, 4'h0, "clear not overriding");
      @(negedge sys_clk);
      master_clear = 1'b0;
      req_up = 1'b0;
      #1 chk(cnt, 4'ha, "load after clear");
      @(negedge sys_clk);
      parallel_load_n = 1'b1;
      @(negedge sys_clk);
      chk(cnt, 4'ha, "edge under load counted");
      $display("override test done");
      // Reset in mid-run clears at once; an up pulse begun at release must still count
      @(negedge sys_clk);
      rst_b = 1'b0;
      #1 chk(cnt, 4'h0, "reset not immediate");
      repeat (2) @(negedge sys_clk);
      rst_b = 1'b1;
      req_up = 1'b1;
      @(negedge sys_clk);
      req_up = 1'b0;
      @(negedge sys_clk);
      chk(cnt, 4'h1, "first count after reset lost");
      $display("reset test done");
      end_sim();
   end
endmodule
